// *** verilog/wfa_pkg.sv ***
package wfa_pkg;

   // ----------------------------------------------------------------
   // geometry
   // ----------------------------------------------------------------
   localparam int NUM_CH      = 8;
   localparam int SEG_W       = 7;
   localparam int BYTE_W      = 7;
   localparam int ADDR_W      = SEG_W + BYTE_W;
   localparam int DATA_W      = 8;
   localparam int REG_ADDR_W  = 4;
   localparam int MEM_DEPTH   = 16384;

   localparam logic [SEG_W-1:0]  SEG_MAX      = 7'h7f;
   localparam logic [BYTE_W-1:0] BYTE_MAX     = 7'h7f;
   localparam logic [BYTE_W-1:0] BYTE_MID     = 7'h40;
   localparam logic [ADDR_W-1:0] ADDR_MAX     = 14'h3fff;

   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [REG_ADDR_W-1:0] REG_CTRL      = 4'h0;
   localparam logic [REG_ADDR_W-1:0] REG_CHMASK    = 4'h1;
   localparam logic [REG_ADDR_W-1:0] REG_DATA      = 4'h2;
   localparam logic [REG_ADDR_W-1:0] REG_SEG       = 4'h3;
   localparam logic [REG_ADDR_W-1:0] REG_BYTE      = 4'h4;
   localparam logic [REG_ADDR_W-1:0] REG_LOOPFIRST = 4'h5;
   localparam logic [REG_ADDR_W-1:0] REG_LOOPLAST  = 4'h6;
   localparam logic [REG_ADDR_W-1:0] REG_STATUS    = 4'h7;
   localparam logic [REG_ADDR_W-1:0] REG_IMASK     = 4'h8;

   // ----------------------------------------------------------------
   // field positions and reset values
   // ----------------------------------------------------------------
   localparam int CTRL_CNT_CLR_BIT = 0;
   localparam int STAT_EOS_BIT     = 0;
   localparam int STAT_MID_BIT     = 1;
   localparam int STAT_W           = 2;

   localparam logic [NUM_CH-1:0] CHMASK_RST    = 8'h01;
   localparam logic [SEG_W-1:0]  LOOPFIRST_RST = 7'h00;
   localparam logic [SEG_W-1:0]  LOOPLAST_RST  = 7'h7f;
   localparam logic [STAT_W-1:0] STATUS_RST    = 2'h0;
   localparam logic [STAT_W-1:0] IMASK_RST     = 2'h0;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS   = 50;
   localparam int PLAY_TICK_NS    = 1000;
   localparam int PLAY_DIV_CYCLES = (PLAY_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0] PLAY_DIV_LAST = 8'(PLAY_DIV_CYCLES - 1);
   localparam int SYNC_W          = 2 + SEG_W;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [REG_ADDR_W-1:0] addr;
      logic [DATA_W-1:0]     wdata;
      logic                  wr;
      logic                  rd;
   } wfa_bus_req_t;

   typedef enum logic [2:0] {
      MODE_IDLE = 3'b001,
      MODE_LOAD = 3'b010,
      MODE_PLAY = 3'b100
   } wfa_mode_t;

endpackage : wfa_pkg

// *** verilog/wfa_sync3.sv ***
`timescale 1ns/10ps
`default_nettype none
module wfa_sync3 #(
   parameter int W = 1
) (
   input  wire logic         mclk,
   input  wire logic         rst,
   input  wire logic         ce,
   input  wire logic [W-1:0] asyncIn,
   output var  logic [W-1:0] syncOut
);

   logic [W-1:0] s1_reg, s2_reg, s3_reg, out_reg;
   logic [W-1:0] out_next;

   // a bit changes only once stages two and three agree
   always_comb begin
      for (int i = 0; i < W; i++) begin
         out_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : out_reg[i];
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         s1_reg  <= '0;
         s2_reg  <= '0;
         s3_reg  <= '0;
         out_reg <= '0;
      end else if (ce) begin
         s1_reg  <= asyncIn;
         s2_reg  <= s1_reg;
         s3_reg  <= s2_reg;
         out_reg <= out_next;
      end
   end

   assign syncOut = out_reg;

endmodule : wfa_sync3
`default_nettype wire

// *** verilog/wfa_chan_mem.sv ***
`timescale 1ns/10ps
`default_nettype none
module wfa_chan_mem (
   input  wire logic                       mclk,
   input  wire logic                       ce,
   input  wire logic                       we,
   input  wire logic [wfa_pkg::ADDR_W-1:0] addr,
   input  wire logic [wfa_pkg::DATA_W-1:0] wdata,
   output var  logic [wfa_pkg::DATA_W-1:0] rdata
);

   // static storage: contents hold indefinitely, so no refresh cycles
   // ever steal host slots
   logic [wfa_pkg::DATA_W-1:0] mem [wfa_pkg::MEM_DEPTH];

   always_ff @(posedge mclk) begin
      if (ce && we) begin
         mem[addr] <= wdata;
      end
   end

   // full 14-bit decode, one cell per address
   always_comb begin
      rdata = mem[addr];
   end

endmodule : wfa_chan_mem
`default_nettype wire

// *** verilog/wfa_addr_top.sv ***
// The implementer's own choices: the address-and-strobe port and the address map.
`timescale 1ns/10ps
`default_nettype none
module wfa_addr_top (
   input  wire logic                          mclk,
   input  wire logic                          rst,
   input  wire logic                          ce,
   input  wire wfa_pkg::wfa_bus_req_t         busReq,
   output var  logic [wfa_pkg::DATA_W-1:0]    rdData,
   input  wire logic                          loadStrobe,
   input  wire logic                          runControl,
   input  wire logic [wfa_pkg::SEG_W-1:0]     segmentNumberOutputs,
   output var  logic                          midSegment,
   output var  logic [wfa_pkg::DATA_W-1:0]    playSample,
   output var  logic                          irq
);

   // ----------------------------------------------------------------
   // functions
   // ----------------------------------------------------------------
   function automatic logic regHit(input wfa_pkg::wfa_bus_req_t r,
                                   input logic [wfa_pkg::REG_ADDR_W-1:0] a);
      regHit = (r.addr == a);
   endfunction : regHit

   // lowest selected channel answers reads
   function automatic logic [2:0] firstSel(input logic [wfa_pkg::NUM_CH-1:0] m);
      firstSel = 3'h0;
      for (int i = wfa_pkg::NUM_CH - 1; i >= 0; i--) begin
         if (m[i]) begin
            firstSel = 3'(i);
         end
      end
   endfunction : firstSel

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [wfa_pkg::SYNC_W-1:0] pinSync;
   logic                       loadLvl;
   logic                       runLvl;
   logic [wfa_pkg::SEG_W-1:0]  segPreset;

   wfa_sync3 #(
      .W (wfa_pkg::SYNC_W)
   ) u_sync (
      .mclk    (mclk),
      .rst     (rst),
      .ce      (ce),
      .asyncIn ({loadStrobe, runControl, segmentNumberOutputs}),
      .syncOut (pinSync)
   );

   assign loadLvl   = pinSync[wfa_pkg::SYNC_W-1];
   assign runLvl    = pinSync[wfa_pkg::SYNC_W-2];
   assign segPreset = pinSync[wfa_pkg::SEG_W-1:0];

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   wfa_pkg::wfa_mode_t          mode_reg, mode_next;
   logic                        loadPrev_reg, loadPrev_next;
   logic                        runPrev_reg, runPrev_next;
   logic [wfa_pkg::SEG_W-1:0]   seg_reg, seg_next;
   logic [wfa_pkg::BYTE_W-1:0]  byte_reg, byte_next;
   logic [7:0]                  div_reg, div_next;
   logic [wfa_pkg::NUM_CH-1:0]  chMask_reg, chMask_next;
   logic [wfa_pkg::SEG_W-1:0]   loopFirst_reg, loopFirst_next;
   logic [wfa_pkg::SEG_W-1:0]   loopLast_reg, loopLast_next;
   logic [wfa_pkg::STAT_W-1:0]  status_reg, status_next;
   logic [wfa_pkg::STAT_W-1:0]  imask_reg, imask_next;
   logic [wfa_pkg::DATA_W-1:0]  rdData_reg, rdData_next;
   logic [wfa_pkg::DATA_W-1:0]  play_reg, play_next;
   logic                        mid_reg, mid_next;
   logic                        irq_reg, irq_next;

   logic                        cntClr, presetEvt, hostAdv, playTick, advance;
   logic                        dataWr, dataRd;
   logic [wfa_pkg::ADDR_W-1:0]  memAddr, addrInc;
   logic [wfa_pkg::STAT_W-1:0]  evt, clr;
   logic [wfa_pkg::NUM_CH-1:0]  chWe;
   logic [wfa_pkg::DATA_W-1:0]  chRd [wfa_pkg::NUM_CH];
   logic [wfa_pkg::DATA_W-1:0]  selRd;

   assign memAddr = {seg_reg, byte_reg};
   assign addrInc = memAddr + 14'h0001;
   assign dataWr  = busReq.wr && regHit(busReq, wfa_pkg::REG_DATA);
   assign dataRd  = busReq.rd && regHit(busReq, wfa_pkg::REG_DATA);
   assign selRd   = chRd[firstSel(chMask_reg)];

   // ----------------------------------------------------------------
   // channel memories
   // ----------------------------------------------------------------
   for (genvar g = 0; g < wfa_pkg::NUM_CH; g++) begin : g_ch
      // only masked-in channels store; all selected store at once
      assign chWe[g] = dataWr && chMask_reg[g];
      wfa_chan_mem u_mem (
         .mclk  (mclk),
         .ce    (ce),
         .we    (chWe[g]),
         .addr  (memAddr),
         .wdata (busReq.wdata),
         .rdata (chRd[g])
      );
      // a selected channel must really hold the byte after the write
      property p_mask_we;
         @(posedge mclk) disable iff (rst)
         ce && dataWr && chMask_reg[g] |=> u_mem.mem[$past(memAddr)] == $past(busReq.wdata);
      endproperty
      a_mask_we: assert property (p_mask_we) else $error("write not stored");
   end

   // ----------------------------------------------------------------
   // mode and address counters
   // ----------------------------------------------------------------
   always_comb begin
      loadPrev_next = loadLvl;
      runPrev_next  = runLvl;
      if (runLvl) begin
         mode_next = wfa_pkg::MODE_PLAY;
      end else if (loadLvl) begin
         mode_next = wfa_pkg::MODE_LOAD;
      end else begin
         mode_next = wfa_pkg::MODE_IDLE;
      end

      cntClr = busReq.wr && regHit(busReq, wfa_pkg::REG_CTRL)
               && busReq.wdata[wfa_pkg::CTRL_CNT_CLR_BIT];
      // any edge of either strobe reloads the segment
      presetEvt = (loadLvl != loadPrev_reg) || (runLvl != runPrev_reg);
      hostAdv   = 1'b0;
      playTick  = 1'b0;
      div_next  = div_reg;
      case (mode_reg)
         wfa_pkg::MODE_LOAD: begin
            hostAdv  = dataWr || dataRd;
            div_next = 8'h00;
         end
         wfa_pkg::MODE_PLAY: begin
            playTick = (div_reg == wfa_pkg::PLAY_DIV_LAST);
            div_next = playTick ? 8'h00 : div_reg + 8'h01;
         end
         wfa_pkg::MODE_IDLE: begin
            div_next = 8'h00;
         end
         default: begin
            div_next = 8'h00;
         end
      endcase
      advance = !cntClr && !presetEvt && (hostAdv || playTick);

      seg_next  = seg_reg;
      byte_next = byte_reg;
      if (cntClr) begin
         seg_next  = '0;
         byte_next = '0;
      end else if (presetEvt) begin
         // full 7-bit preset, any order
         seg_next  = segPreset;
         byte_next = '0;
      end else if (playTick && byte_reg == wfa_pkg::BYTE_MAX
                   && seg_reg == loopLast_reg) begin
         seg_next  = loopFirst_reg;
         byte_next = '0;
      end else if (advance) begin
         // byte wrap carries into segment
         seg_next  = addrInc[wfa_pkg::ADDR_W-1:wfa_pkg::BYTE_W];
         byte_next = addrInc[wfa_pkg::BYTE_W-1:0];
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         mode_reg     <= wfa_pkg::MODE_IDLE;
         loadPrev_reg <= 1'b0;
         runPrev_reg  <= 1'b0;
         seg_reg      <= '0;
         byte_reg     <= '0;
         div_reg      <= 8'h00;
      end else if (ce) begin
         mode_reg     <= mode_next;
         loadPrev_reg <= loadPrev_next;
         runPrev_reg  <= runPrev_next;
         seg_reg      <= seg_next;
         byte_reg     <= byte_next;
         div_reg      <= div_next;
      end
   end

   // ----------------------------------------------------------------
   // registers, flags and interrupt
   // ----------------------------------------------------------------
   always_comb begin
      chMask_next    = chMask_reg;
      loopFirst_next = loopFirst_reg;
      loopLast_next  = loopLast_reg;
      imask_next     = imask_reg;
      clr            = '0;
      if (busReq.wr) begin
         case (busReq.addr)
            wfa_pkg::REG_CHMASK:    chMask_next    = busReq.wdata;
            wfa_pkg::REG_LOOPFIRST: loopFirst_next = busReq.wdata[wfa_pkg::SEG_W-1:0];
            wfa_pkg::REG_LOOPLAST:  loopLast_next  = busReq.wdata[wfa_pkg::SEG_W-1:0];
            wfa_pkg::REG_STATUS:    clr            = busReq.wdata[wfa_pkg::STAT_W-1:0];
            wfa_pkg::REG_IMASK:     imask_next     = busReq.wdata[wfa_pkg::STAT_W-1:0];
            default:                clr            = '0;
         endcase
      end

      evt = '0;
      // stepping off the very last byte ends the sound
      evt[wfa_pkg::STAT_EOS_BIT] = advance && (memAddr == wfa_pkg::ADDR_MAX);
      evt[wfa_pkg::STAT_MID_BIT] = advance && !(seg_next != seg_reg)
                                   && (byte_next == wfa_pkg::BYTE_MID);
      // set beats clear in the same cycle
      status_next = (status_reg & ~clr) | evt;
      mid_next    = byte_next[wfa_pkg::BYTE_W-1];
      irq_next    = |(status_next & imask_reg);

      rdData_next = '0;
      if (busReq.rd) begin
         case (busReq.addr)
            wfa_pkg::REG_CTRL:      rdData_next = {5'h00, mode_reg};
            wfa_pkg::REG_CHMASK:    rdData_next = chMask_reg;
            wfa_pkg::REG_DATA:      rdData_next = selRd;
            wfa_pkg::REG_SEG:       rdData_next = {1'b0, seg_reg};
            wfa_pkg::REG_BYTE:      rdData_next = {1'b0, byte_reg};
            wfa_pkg::REG_LOOPFIRST: rdData_next = {1'b0, loopFirst_reg};
            wfa_pkg::REG_LOOPLAST:  rdData_next = {1'b0, loopLast_reg};
            wfa_pkg::REG_STATUS:    rdData_next = {6'h00, status_reg};
            wfa_pkg::REG_IMASK:     rdData_next = {6'h00, imask_reg};
            default:                rdData_next = '0;
         endcase
      end
      play_next = playTick ? selRd : play_reg;
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         chMask_reg    <= wfa_pkg::CHMASK_RST;
         loopFirst_reg <= wfa_pkg::LOOPFIRST_RST;
         loopLast_reg  <= wfa_pkg::LOOPLAST_RST;
         status_reg    <= wfa_pkg::STATUS_RST;
         imask_reg     <= wfa_pkg::IMASK_RST;
         rdData_reg    <= '0;
         play_reg      <= '0;
         mid_reg       <= 1'b0;
         irq_reg       <= 1'b0;
      end else if (ce) begin
         chMask_reg    <= chMask_next;
         loopFirst_reg <= loopFirst_next;
         loopLast_reg  <= loopLast_next;
         status_reg    <= status_next;
         imask_reg     <= imask_next;
         rdData_reg    <= rdData_next;
         play_reg      <= play_next;
         mid_reg       <= mid_next;
         irq_reg       <= irq_next;
      end
   end

   assign rdData     = rdData_reg;
   assign playSample = play_reg;
   assign midSegment = mid_reg;
   assign irq        = irq_reg;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);

   property p_cnt_clr;
      ce && cntClr |=> (seg_reg == '0) && (byte_reg == '0);
   endproperty
   a_cnt_clr: assert property (p_cnt_clr) else $error("counter clear failed");

   property p_host_adv;
      ce && hostAdv && !cntClr && !presetEvt
         |=> memAddr == $past(memAddr) + 14'h0001;
   endproperty
   a_host_adv: assert property (p_host_adv) else $error("no advance on access");

   property p_no_adv_idle;
      ce && mode_reg == wfa_pkg::MODE_IDLE && !cntClr && !presetEvt
         |=> memAddr == $past(memAddr);
   endproperty
   a_no_adv_idle: assert property (p_no_adv_idle) else $error("address moved when idle");

   property p_preset;
      ce && presetEvt && !cntClr |=> seg_reg == $past(segPreset) && byte_reg == '0;
   endproperty
   a_preset: assert property (p_preset) else $error("segment preset failed");

   property p_loop;
      ce && playTick && !presetEvt && !cntClr && memAddr[wfa_pkg::BYTE_W-1:0] == wfa_pkg::BYTE_MAX
         && seg_reg == loopLast_reg |=> seg_reg == $past(loopFirst_reg) && byte_reg == '0;
   endproperty
   a_loop: assert property (p_loop) else $error("playback did not loop");

   property p_eos;
      ce && advance && memAddr == wfa_pkg::ADDR_MAX
         |=> status_reg[wfa_pkg::STAT_EOS_BIT]
             && (irq || !$past(imask_reg[wfa_pkg::STAT_EOS_BIT]));
   endproperty
   a_eos: assert property (p_eos) else $error("end of sound not flagged");

   property p_mid;
      ce |=> midSegment == (byte_reg >= wfa_pkg::BYTE_MID);
   endproperty
   a_mid: assert property (p_mid) else $error("mid flag wrong");

   property p_carry;
      ce && advance && !playTick && byte_reg == wfa_pkg::BYTE_MAX && seg_reg != wfa_pkg::SEG_MAX
         |=> seg_reg == $past(seg_reg) + 7'h01 && byte_reg == '0;
   endproperty
   a_carry: assert property (p_carry) else $error("no carry into segment");

endmodule : wfa_addr_top
`default_nettype wire

// *** verif/wfa_port_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// host parallel port: segment number pins plus load and run lines
// ----------------------------------------------------------------
module wfa_port_model (
   input  wire logic                      mclk,
   input  wire logic [wfa_pkg::SEG_W-1:0] presetSeg,
   input  wire logic                      loadReq,
   input  wire logic                      runReq,
   output var  logic [wfa_pkg::SEG_W-1:0] segmentNumberOutputs,
   output var  logic                      loadStrobe,
   output var  logic                      runControl
);
   logic [3:0] ldDly;
   logic [3:0] rnDly;

   initial begin
      ldDly = '0;
      rnDly = '0;
      segmentNumberOutputs = '0;
      loadStrobe = 1'b0;
      runControl = 1'b0;
   end

   // strobes lag the pins by four cycles, so the preset value is
   // already settled and held when the card sees the toggle
   always @(posedge mclk) begin
      segmentNumberOutputs <= presetSeg;
      ldDly <= {ldDly[2:0], loadReq};
      rnDly <= {rnDly[2:0], runReq};
      loadStrobe <= ldDly[3];
      runControl <= rnDly[3];
   end
endmodule : wfa_port_model
`default_nettype wire

// *** verif/tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb;
   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   logic                       mclk = 1'b0;
   logic                       rst = 1'b1;
   logic                       ce = 1'b1;
   wfa_pkg::wfa_bus_req_t      busReq = '0;
   logic [wfa_pkg::DATA_W-1:0] rdData;
   logic [wfa_pkg::DATA_W-1:0] playSample;
   logic [wfa_pkg::SEG_W-1:0]  segPins;
   logic [wfa_pkg::SEG_W-1:0]  presetSeg = '0;
   logic                       loadReq = 1'b0;
   logic                       runReq = 1'b0;
   logic                       loadStrobe;
   logic                       runControl;
   logic                       midSegment;
   logic                       irq;
   logic [7:0]                 d;
   int                         miscompares = 0;
   int                         checkCount = 0;
   int                         cycles = 0;

   always #25 mclk = ~mclk;

   wfa_addr_top i_wfa_addr_top (
      .mclk(mclk), .rst(rst), .ce(ce), .busReq(busReq), .rdData(rdData),
      .loadStrobe(loadStrobe), .runControl(runControl),
      .segmentNumberOutputs(segPins), .midSegment(midSegment),
      .playSample(playSample), .irq(irq));

   wfa_port_model i_wfa_port_model (
      .mclk(mclk), .presetSeg(presetSeg), .loadReq(loadReq), .runReq(runReq),
      .segmentNumberOutputs(segPins), .loadStrobe(loadStrobe),
      .runControl(runControl));

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic final_report;
      if (miscompares == 0 && checkCount > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : final_report

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checkCount++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge mclk) busReq <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge mclk) busReq <= '0;
   endtask : wr

   // read data stand only in the cycle after the strobe
   task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
      @(posedge mclk) busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge mclk) busReq <= '0;
      #1 d = rdData;
      check({8'h00, d}, {8'h00, exp});
   endtask : rdchk

   task automatic pins(input logic [6:0] s, input logic ld, input logic rn);
      @(posedge mclk) begin
         presetSeg <= s;
         loadReq <= ld;
         runReq <= rn;
      end
      repeat (14) @(posedge mclk);
   endtask : pins

   task automatic irqchk(input logic exp);
      @(posedge mclk);
      #1 check({15'h0, irq}, {15'h0, exp});
   endtask : irqchk

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_reset;
      #1 check({14'h0, midSegment, irq}, 16'h0);
      rdchk(wfa_pkg::REG_CTRL, 8'h01);
      rdchk(wfa_pkg::REG_CHMASK, 8'h01);
      rdchk(wfa_pkg::REG_LOOPFIRST, 8'h00);
      rdchk(wfa_pkg::REG_LOOPLAST, 8'h7f);
      rdchk(wfa_pkg::REG_STATUS, 8'h00);
      rdchk(wfa_pkg::REG_IMASK, 8'h00);
      rdchk(wfa_pkg::REG_SEG, 8'h00);
      rdchk(4'hf, 8'h00);
      @(posedge mclk) ce <= 1'b0;
      wr(wfa_pkg::REG_CHMASK, 8'hff);
      @(posedge mclk) ce <= 1'b1;
      rdchk(wfa_pkg::REG_CHMASK, 8'h01);
   endtask : t_reset

   task automatic t_load_seq;
      pins(7'h00, 1'b1, 1'b0);
      rdchk(wfa_pkg::REG_CTRL, 8'h02);
      wr(wfa_pkg::REG_CHMASK, 8'h05);
      for (int i = 0; i < 130; i++) begin
         wr(wfa_pkg::REG_DATA, 8'(i));
         #1 check({15'h0, midSegment}, {15'h0, 1'((i + 1) % 128 >= 64)});
      end
      rdchk(wfa_pkg::REG_SEG, 8'h01);
      rdchk(wfa_pkg::REG_BYTE, 8'h02);
      rdchk(wfa_pkg::REG_STATUS, 8'h02);
      wr(wfa_pkg::REG_IMASK, 8'h02);
      irqchk(1'b1);
      wr(wfa_pkg::REG_STATUS, 8'h02);
      irqchk(1'b0);
      wr(wfa_pkg::REG_CTRL, 8'h01);
      rdchk(wfa_pkg::REG_SEG, 8'h00);
      rdchk(wfa_pkg::REG_BYTE, 8'h00);
      wr(wfa_pkg::REG_CHMASK, 8'h04);
      for (int i = 0; i < 130; i++) begin
         rdchk(wfa_pkg::REG_DATA, 8'(i));
      end
      wr(wfa_pkg::REG_CTRL, 8'h01);
      wr(wfa_pkg::REG_CHMASK, 8'h02);
      wr(wfa_pkg::REG_DATA, 8'hc3);
      wr(wfa_pkg::REG_CTRL, 8'h01);
      wr(wfa_pkg::REG_CHMASK, 8'h01);
      rdchk(wfa_pkg::REG_DATA, 8'h00);
      wr(wfa_pkg::REG_CTRL, 8'h01);
      wr(wfa_pkg::REG_CHMASK, 8'h02);
      rdchk(wfa_pkg::REG_DATA, 8'hc3);
   endtask : t_load_seq

   task automatic t_eos;
      wr(wfa_pkg::REG_IMASK, 8'h01);
      pins(7'h7f, 1'b0, 1'b0);
      pins(7'h7f, 1'b1, 1'b0);
      rdchk(wfa_pkg::REG_SEG, 8'h7f);
      for (int i = 0; i < 127; i++) begin
         wr(wfa_pkg::REG_DATA, 8'h5a);
         #1 check({15'h0, irq}, 16'h0);
      end
      wr(wfa_pkg::REG_DATA, 8'h5a);
      irqchk(1'b1);
      rdchk(wfa_pkg::REG_STATUS, 8'h03);
      rdchk(wfa_pkg::REG_SEG, 8'h00);
      wr(wfa_pkg::REG_STATUS, 8'h03);
      irqchk(1'b0);
   endtask : t_eos

   task automatic t_random_seg;
      logic [6:0] segs [6] = '{7'h7f, 7'h00, 7'h55, 7'h2a, 7'h01, 7'h40};
      for (int i = 0; i < 6; i++) begin
         pins(segs[i], ~loadReq, 1'b0);
         rdchk(wfa_pkg::REG_SEG, {1'b0, segs[i]});
      end
      for (int i = 0; i < 6; i++) begin
         pins(segs[5 - i], 1'b0, ~runReq);
         rdchk(wfa_pkg::REG_SEG, {1'b0, segs[5 - i]});
      end
   endtask : t_random_seg

   // one pass of segment 3 takes 128 ticks of 20 cycles
   task automatic t_loop;
      wr(wfa_pkg::REG_LOOPFIRST, 8'h02);
      wr(wfa_pkg::REG_LOOPLAST, 8'h03);
      pins(7'h03, 1'b0, 1'b1);
      // byte 0 of segment 3 is written before the first play tick
      wr(wfa_pkg::REG_DATA, 8'h96);
      rdchk(wfa_pkg::REG_CTRL, 8'h04);
      rdchk(wfa_pkg::REG_SEG, 8'h03);
      repeat (20) @(posedge mclk);
      #1 check({8'h00, playSample}, 16'h0096);
      repeat (2680) @(posedge mclk);
      rdchk(wfa_pkg::REG_SEG, 8'h02);
   endtask : t_loop

   task automatic t_retain;
      pins(7'h00, 1'b1, 1'b0);
      wr(wfa_pkg::REG_CHMASK, 8'h01);
      wr(wfa_pkg::REG_CTRL, 8'h01);
      rdchk(wfa_pkg::REG_DATA, 8'h00);
      rdchk(wfa_pkg::REG_DATA, 8'h01);
   endtask : t_retain

   // ----------------------------------------------------------------
   // main sequence and hang guard
   // ----------------------------------------------------------------
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 12000) begin
         miscompares++;
         final_report();
      end
   end

   initial begin
      repeat (12) @(posedge mclk);
      rst <= 1'b0;
      repeat (2) @(posedge mclk);
      t_reset();
      t_load_seq();
      t_eos();
      t_random_seg();
      t_loop();
      t_retain();
      final_report();
   end
endmodule : tb
`default_nettype wire
